// ### vcp_consts.svh
`ifndef VCP_CONSTS_SVH
`define VCP_CONSTS_SVH

// ==========================================================
// Clocking and timing
`define VCP_REF_CLK_MHZ 200
`define VCP_MCLK_LOSS_NS 2000
`define VCP_MCLK_LOSS_CYC ((`VCP_MCLK_LOSS_NS * `VCP_REF_CLK_MHZ) / 1000)
`define VCP_FRAME_LAST 8'hFF

// ==========================================================
// Word lengths
`define VCP_TX_LIN_LAST 5'h0C
`define VCP_TX_CMP_LAST 5'h07
`define VCP_RX_LIN_BITS 5'h10
`define VCP_RX_CMP_BITS 5'h08
`define VCP_GAIN_0DB 3'h1

// ==========================================================
// Mu-law arithmetic
`define VCP_MU_CLIP 14'h1FDE
`define VCP_MU_BIAS 14'h0021
`define VCP_MU_DEC_BIAS 16'h0084

// ==========================================================
// Register word indices (byte address = 4 * index)
`define VCP_IDX_CTRL 6'h00
`define VCP_IDX_TX_DATA 6'h01
`define VCP_IDX_RX_DATA 6'h02
`define VCP_IDX_STATUS 6'h03
`define VCP_IDX_GAIN 6'h04
`define VCP_CTRL_PD_BIT 0
`define VCP_ST_OVR_BIT 1
`define VCP_ST_FERR_BIT 2
`define VCP_RESP_OKAY 2'h0
`define VCP_RESP_SLVERR 2'h2

`endif

// ### vcp_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module vcp_fifo2 (
   input wire logic i_clk,
   input wire logic i_rst_n,
   vcp_stream_if.snk fill,
   vcp_stream_if.src drain
);
   vcp_pkg::vcp_word_t mem_r [2];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] count_r;
   logic push;
   logic pop;

   assign fill.ready = (count_r != 2'h2);
   assign drain.valid = (count_r != 2'h0);
   assign drain.data = mem_r[rd_ptr_r];
   assign push = fill.valid & fill.ready;
   assign pop = drain.valid & drain.ready;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) wr_ptr_r <= ~wr_ptr_r;
         if (pop) rd_ptr_r <= ~rd_ptr_r;
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) mem_r[wr_ptr_r] <= fill.data;
   end
endmodule
`default_nettype wire

// ### vcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vcp_host_model (
   input wire logic i_run,
   input wire logic [15:0] i_rx_word,
   input wire logic [4:0] i_rx_bits,
   input wire logic i_tx_out,
   input wire logic i_tx_oe,
   output logic o_mclk = 1'b0,
   output logic o_frame_strobe = 1'b0,
   output logic o_serial_rx_in = 1'b0,
   output logic [15:0] o_tx_word = 16'h0000,
   output logic [4:0] o_tx_bits = 5'h00
);
   logic [7:0] slot_r = 8'hC8;
   // Clock stands still once stopped, as a lost clock would
   always #244 if (i_run) o_mclk = ~o_mclk;
   // Strobe covers slot 0 so it is stable around that falling edge
   always @(posedge o_mclk) begin
      slot_r <= slot_r + 8'h01;
      o_frame_strobe <= (slot_r == 8'hFF);
      if (slot_r < 8'(i_rx_bits))
         o_serial_rx_in <= i_rx_word[i_rx_bits - 5'(slot_r) - 5'h01];
      else
         o_serial_rx_in <= ~o_serial_rx_in;
   end
   always @(negedge o_mclk) begin
      if (o_frame_strobe) begin
         o_tx_word <= 16'h0000;
         o_tx_bits <= 5'h00;
      end else if (i_tx_oe) begin
         o_tx_word <= {o_tx_word[14:0], i_tx_out};
         o_tx_bits <= o_tx_bits + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ### vcp_pkg.sv
package vcp_pkg;
   // Receive word: {gain code[2:0], sample[12:0]}
   typedef logic [15:0] vcp_word_t;
   typedef enum logic [1:0] {
      VCP_TX_IDLE = 2'b00,
      VCP_TX_ARMED = 2'b01,
      VCP_TX_SHIFT = 2'b10
   } vcp_tx_state_t;
endpackage

// ### vcp_serial_port.sv
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vcp_consts.svh"

// How it works
// - Strobe rate 8 kHz; one sample per frame each direction.
// - Frame strobe is sampled on the falling master clock edge.
// - Receive bits are captured on falling master clock edges.
// - Transmit bits driven after rising edges; released after last falling edge.
// - Both directions send the most significant bit first.
// - Loss of master clock powers down and floats the transmit pin.
// - Power-down during a transmit word waits until the word ends.
// - Linear is 13-bit two's complement; companded is 8-bit mu-law.
// - Law select low picks linear, high picks companded.
// - Transmit mute high attenuates the microphone signal 80 dB.
// - Receive mute high mutes the receive channel.
// - Receive word: 8 bits companded; 13 sample plus 3 gain bits linear.
// - Gain code 000 is +3 dB, then 3 dB lower per step to -18 dB.
// - Companded mode uses fixed 0 dB receive gain, ignoring codes.
module vcp_serial_port (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_mclk,
   input wire logic i_frame_strobe,
   input wire logic i_serial_rx_in,
   input wire logic i_law_select_n,
   input wire logic i_tx_mute,
   input wire logic i_rx_mute,
   output logic o_serial_tx_out,
   output logic o_serial_tx_oe,
   output logic o_power_down,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready
);
   // ==========================================================
   // Conversion helpers
   function automatic logic [7:0] mu_encode(input logic [12:0] lin);
      logic [13:0] x;
      logic [13:0] mag;
      logic [2:0] seg;
      logic [3:0] man;
      x = {lin, 1'b0};
      mag = x[13] ? 14'(~x + 14'h0001) : x;
      if (mag > `VCP_MU_CLIP) mag = `VCP_MU_CLIP;
      mag = mag + `VCP_MU_BIAS;
      seg = 3'h0;
      for (int i = 5; i < 13; i++) begin
         if (mag[i]) seg = 3'(i - 5);
      end
      man = mag[4'(seg) + 4'h1 +: 4];
      return ~{x[13], seg, man};
   endfunction

   function automatic logic [12:0] mu_decode(input logic [7:0] code);
      logic [7:0] t;
      logic [15:0] val;
      logic [12:0] mag;
      t = ~code;
      val = (({12'h000, t[3:0]} << 3) + `VCP_MU_DEC_BIAS) << t[6:4];
      val = val - `VCP_MU_DEC_BIAS;
      mag = val[15:3];
      return t[7] ? 13'(~mag + 13'h0001) : mag;
   endfunction

   function automatic logic signed [7:0] gain_db(input logic [2:0] code);
      return 8'sh03 - 8'sh03 * $signed({5'h00, code});
   endfunction

   // ==========================================================
   // Reset release and pin synchronisers
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic [5:0] pin_s1_r;
   logic [5:0] pin_s2_r;
   logic mclk_d_r;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) rst_sync_r <= 2'h0;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 6'h00;
         pin_s2_r <= 6'h00;
         mclk_d_r <= 1'b0;
      end else begin
         pin_s1_r <= {i_mclk, i_frame_strobe, i_serial_rx_in,
                      i_law_select_n, i_tx_mute, i_rx_mute};
         pin_s2_r <= pin_s1_r;
         mclk_d_r <= pin_s2_r[5];
      end
   end

   logic mclk_rise;
   logic mclk_fall;
   logic strobe_s;
   logic rx_bit_s;
   logic linear_s;
   logic tx_mute_s;
   logic rx_mute_s;
   assign mclk_rise = pin_s2_r[5] & ~mclk_d_r;
   assign mclk_fall = ~pin_s2_r[5] & mclk_d_r;
   assign strobe_s = pin_s2_r[4];
   assign rx_bit_s = pin_s2_r[3];
   assign linear_s = ~pin_s2_r[2];
   assign tx_mute_s = pin_s2_r[1];
   assign rx_mute_s = pin_s2_r[0];

   // ==========================================================
   // Clock loss, power-down and frame spacing
   logic [11:0] loss_cnt_r;
   logic clk_lost_r;
   logic pd_r;
   logic ctrl_pd_r;
   logic [7:0] fr_cnt_r;
   logic fr_seen_r;
   logic frame_err_r;
   logic lin_frame_r;
   logic frame_start;
   logic tx_idle;
   logic rx_active_r;
   vcp_pkg::vcp_tx_state_t tx_state_r;

   // Frames start only on a sampled strobe and only while powered
   assign frame_start = mclk_fall & strobe_s & ~ctrl_pd_r & ~clk_lost_r;
   assign tx_idle = (tx_state_r == vcp_pkg::VCP_TX_IDLE);

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         loss_cnt_r <= 12'h000;
         clk_lost_r <= 1'b0;
         pd_r <= 1'b0;
      end else begin
         if (mclk_rise | mclk_fall) loss_cnt_r <= 12'h000;
         else if (!clk_lost_r) loss_cnt_r <= loss_cnt_r + 12'h001;
         clk_lost_r <= (loss_cnt_r >= 12'(`VCP_MCLK_LOSS_CYC));
         pd_r <= clk_lost_r | (ctrl_pd_r & tx_idle & ~rx_active_r);
      end
   end

   // Spacing is checked, not enforced: a short frame still restarts the word
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fr_cnt_r <= 8'h00;
         fr_seen_r <= 1'b0;
         lin_frame_r <= 1'b0;
      end else if (frame_start) begin
         fr_cnt_r <= 8'h00;
         fr_seen_r <= 1'b1;
         lin_frame_r <= linear_s;
      end else if (mclk_fall) begin
         fr_cnt_r <= fr_cnt_r + 8'h01;
      end
   end

   logic frame_bad;
   logic ferr_clr;
   assign frame_bad = frame_start & fr_seen_r & (fr_cnt_r != `VCP_FRAME_LAST);

   // ==========================================================
   // Transmit shifter
   logic [12:0] tx_sr_r;
   logic [4:0] tx_cnt_r;
   logic tx_out_r;
   logic tx_oe_r;
   logic [12:0] tx_data_r;
   logic [12:0] tx_lin;
   logic [12:0] tx_load;
   assign tx_lin = tx_mute_s ? 13'h0000 : tx_data_r;
   assign tx_load = lin_frame_r ? tx_lin : {mu_encode(tx_lin), 5'h00};

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_r <= vcp_pkg::VCP_TX_IDLE;
         tx_sr_r <= 13'h0000;
         tx_cnt_r <= 5'h00;
         tx_out_r <= 1'b0;
         tx_oe_r <= 1'b0;
      end else if (clk_lost_r) begin
         tx_state_r <= vcp_pkg::VCP_TX_IDLE;
         tx_out_r <= 1'b0;
         tx_oe_r <= 1'b0;
      end else begin
         unique case (tx_state_r)
            vcp_pkg::VCP_TX_IDLE: begin
               if (frame_start) tx_state_r <= vcp_pkg::VCP_TX_ARMED;
            end
            vcp_pkg::VCP_TX_ARMED: begin
               if (mclk_rise) begin
                  tx_sr_r <= {tx_load[11:0], 1'b0};
                  tx_out_r <= tx_load[12];
                  tx_oe_r <= 1'b1;
                  tx_cnt_r <= lin_frame_r ? `VCP_TX_LIN_LAST : `VCP_TX_CMP_LAST;
                  tx_state_r <= vcp_pkg::VCP_TX_SHIFT;
               end
            end
            vcp_pkg::VCP_TX_SHIFT: begin
               if (mclk_fall && tx_cnt_r == 5'h00) begin
                  tx_oe_r <= 1'b0;
                  tx_out_r <= 1'b0;
                  tx_state_r <= vcp_pkg::VCP_TX_IDLE;
               end else if (mclk_rise) begin
                  tx_out_r <= tx_sr_r[12];
                  tx_sr_r <= {tx_sr_r[11:0], 1'b0};
                  tx_cnt_r <= tx_cnt_r - 5'h01;
               end
            end
            default: tx_state_r <= vcp_pkg::VCP_TX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Receive shifter
   logic [15:0] rx_sr_r;
   logic [4:0] rx_cnt_r;
   logic rx_push_r;
   vcp_pkg::vcp_word_t rx_word_r;
   logic rx_done;
   logic [15:0] rx_sr_nxt;
   logic [12:0] rx_sample;
   logic [2:0] rx_gain;
   assign rx_sr_nxt = {rx_sr_r[14:0], rx_bit_s};
   assign rx_done = rx_active_r & mclk_fall & (rx_cnt_r == 5'h01);
   assign rx_sample = rx_mute_s ? 13'h0000 :
                      lin_frame_r ? rx_sr_nxt[15:3] : mu_decode(rx_sr_nxt[7:0]);
   assign rx_gain = lin_frame_r ? rx_sr_nxt[2:0] : `VCP_GAIN_0DB;

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_active_r <= 1'b0;
         rx_sr_r <= 16'h0000;
         rx_cnt_r <= 5'h00;
         rx_push_r <= 1'b0;
         rx_word_r <= 16'h0000;
      end else begin
         rx_push_r <= 1'b0;
         if (clk_lost_r) begin
            rx_active_r <= 1'b0;
         end else if (frame_start) begin
            rx_active_r <= 1'b1;
            rx_cnt_r <= linear_s ? `VCP_RX_LIN_BITS : `VCP_RX_CMP_BITS;
         end else if (rx_active_r && mclk_fall) begin
            rx_sr_r <= rx_sr_nxt;
            rx_cnt_r <= rx_cnt_r - 5'h01;
            if (rx_done) begin
               rx_active_r <= 1'b0;
               rx_push_r <= 1'b1;
               rx_word_r <= {rx_gain, rx_sample};
            end
         end
      end
   end

   // ==========================================================
   // Receive buffer: two words absorb a slow reader
   vcp_stream_if rx_in ();
   vcp_stream_if rx_out ();
   logic overrun_r;
   logic ovr_clr;
   logic rx_pop;
   assign rx_in.valid = rx_push_r;
   assign rx_in.data = rx_word_r;
   assign rx_out.ready = rx_pop;

   vcp_fifo2 u_rx_buf (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .fill(rx_in.snk),
      .drain(rx_out.src)
   );

   // ==========================================================
   // AXI4-Lite slave
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [5:0] aw_idx_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [2:0] last_gain_r;
   logic wr_do;
   logic wr_ctrl;
   logic wr_tx;
   logic wr_stat;
   logic ar_take;
   logic [5:0] rd_idx;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic rd_ok;

   assign wr_do = ~awready_r & ~wready_r & ~bvalid_r;
   assign wr_ctrl = wr_do & (aw_idx_r == `VCP_IDX_CTRL);
   assign wr_tx = wr_do & (aw_idx_r == `VCP_IDX_TX_DATA);
   assign wr_stat = wr_do & (aw_idx_r == `VCP_IDX_STATUS) & wstrb_r[0];
   assign ovr_clr = wr_stat & wdata_r[`VCP_ST_OVR_BIT];
   assign ferr_clr = wr_stat & wdata_r[`VCP_ST_FERR_BIT];
   assign ar_take = i_s_axi_arvalid & arready_r;
   assign rd_idx = i_s_axi_araddr[7:2];
   assign rx_pop = ar_take & (rd_idx == `VCP_IDX_RX_DATA);
   assign rd_ok = (rd_idx <= `VCP_IDX_GAIN);
   assign status_word = {23'h000000, ~tx_idle, rx_mute_s, tx_mute_s, linear_s,
                         clk_lost_r, pd_r, frame_err_r, overrun_r, rx_out.valid};
   assign rd_mux = (rd_idx == `VCP_IDX_CTRL) ? {31'h00000000, ctrl_pd_r} :
                   (rd_idx == `VCP_IDX_TX_DATA) ? {19'h00000, tx_data_r} :
                   (rd_idx == `VCP_IDX_RX_DATA) ? {15'h0000, rx_out.valid, rx_out.data} :
                   (rd_idx == `VCP_IDX_STATUS) ? status_word :
                   (rd_idx == `VCP_IDX_GAIN) ? {24'h000000, gain_db(last_gain_r)} :
                   32'h00000000;

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= `VCP_RESP_OKAY;
         aw_idx_r <= 6'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         if (i_s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_idx_r <= i_s_axi_awaddr[7:2];
         end
         if (i_s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r <= i_s_axi_wdata;
            wstrb_r <= i_s_axi_wstrb;
         end
         if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_idx_r <= `VCP_IDX_GAIN) ? `VCP_RESP_OKAY : `VCP_RESP_SLVERR;
         end else if (bvalid_r && i_s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= `VCP_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_ok ? `VCP_RESP_OKAY : `VCP_RESP_SLVERR;
      end else if (rvalid_r && i_s_axi_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // Register fields; a hardware set wins over a same-cycle clear
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_pd_r <= 1'b0;
         tx_data_r <= 13'h0000;
         overrun_r <= 1'b0;
         frame_err_r <= 1'b0;
         last_gain_r <= `VCP_GAIN_0DB;
      end else begin
         if (wr_ctrl && wstrb_r[0]) ctrl_pd_r <= wdata_r[`VCP_CTRL_PD_BIT];
         if (wr_tx && wstrb_r[0]) tx_data_r[7:0] <= wdata_r[7:0];
         if (wr_tx && wstrb_r[1]) tx_data_r[12:8] <= wdata_r[12:8];
         overrun_r <= (rx_in.valid & ~rx_in.ready) | (overrun_r & ~ovr_clr);
         frame_err_r <= frame_bad | (frame_err_r & ~ferr_clr);
         if (rx_push_r) last_gain_r <= rx_word_r[15:13];
      end
   end

   // ==========================================================
   // Outputs
   assign o_serial_tx_out = tx_out_r;
   assign o_serial_tx_oe = tx_oe_r;
   assign o_power_down = pd_r;
   assign o_s_axi_awready = awready_r;
   assign o_s_axi_wready = wready_r;
   assign o_s_axi_bvalid = bvalid_r;
   assign o_s_axi_bresp = bresp_r;
   assign o_s_axi_arready = arready_r;
   assign o_s_axi_rvalid = rvalid_r;
   assign o_s_axi_rresp = rresp_r;
   assign o_s_axi_rdata = rdata_r;
endmodule
`default_nettype wire

// ### vcp_serial_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "vcp_consts.svh"
module vcp_serial_port_bench;
   logic ref_clk = 0, rst_n = 1, law_n = 0, tx_mute = 0, rx_mute = 0, run = 1;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 4'hF;
   logic [15:0] rx_word = 16'h55E3;
   logic [4:0] rx_bits = 5'h10;
   wire mclk, strobe, rx_in, tx_out, tx_oe, pd, awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] tx_word;
   wire [4:0] tx_bits;
   int n_fail = 0, num_checks = 0;
   localparam logic [7:0] A_CTRL = {`VCP_IDX_CTRL, 2'b00}, A_TX = {`VCP_IDX_TX_DATA, 2'b00};
   localparam logic [7:0] A_RX = {`VCP_IDX_RX_DATA, 2'b00}, A_ST = {`VCP_IDX_STATUS, 2'b00};
   localparam logic [7:0] A_GAIN = {`VCP_IDX_GAIN, 2'b00};
   always #2.5 ref_clk = ~ref_clk;
   vcp_serial_port u_vcp_serial_port (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_mclk(mclk),
      .i_frame_strobe(strobe), .i_serial_rx_in(rx_in), .i_law_select_n(law_n),
      .i_tx_mute(tx_mute), .i_rx_mute(rx_mute), .o_serial_tx_out(tx_out),
      .o_serial_tx_oe(tx_oe), .o_power_down(pd), .i_s_axi_awaddr(awaddr),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready));
   vcp_host_model u_vcp_host_model (.i_run(run), .i_rx_word(rx_word), .i_rx_bits(rx_bits),
      .i_tx_out(tx_out), .i_tx_oe(tx_oe), .o_mclk(mclk), .o_frame_strobe(strobe),
      .o_serial_rx_in(rx_in), .o_tx_word(tx_word), .o_tx_bits(tx_bits));
   // ==========================================================
   // Shared tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic timeout(input int i);
      if (i >= 40000) begin
         n_fail++;
         end_sim();
      end
   endtask
   // Ready is read right at the edge, so it is the value the slave sampled there
   // Response ready is raised late so the slave must hold its answer a cycle
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 200 && !(bvalid === 1'b1 && bready); i++) begin
         @(posedge ref_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1 && !bready) bready <= 1'b1;
      end
      timeout(i * 200);
      chk(32'(bresp), 32'(er));
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, ed, input logic [1:0] er);
      int i;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      for (i = 0; i < 200 && !(rvalid === 1'b1 && rready); i++) begin
         @(posedge ref_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1 && !rready) rready <= 1'b1;
      end
      timeout(i * 200);
      chk(rdata & m, ed);
      chk(32'(rresp), 32'(er));
      rready <= 1'b0;
   endtask
   task automatic wait_oe(input logic lvl);
      int i;
      for (i = 0; i < 40000 && tx_oe !== lvl; i++) @(negedge ref_clk);
      timeout(i);
   endtask
   task automatic frame_end(input logic [15:0] ew, input logic [4:0] eb);
      wait_oe(0);
      // Receive word ends three master clocks after the transmit word in linear mode, on the same clock in companded
      repeat (400) @(negedge ref_clk);
      chk(32'(tx_word), 32'(ew));
      chk(32'(tx_bits), 32'(eb));
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk(32'({pd, tx_oe}), 32'h0);
      axi_rd(A_CTRL, 32'h1, 32'h0, `VCP_RESP_OKAY);
      axi_rd(8'h40, 32'hFFFFFFFF, 32'h0, `VCP_RESP_SLVERR);
      axi_wr(8'h40, 32'h1, `VCP_RESP_SLVERR);
      axi_wr(A_RX, 32'hFFFF, `VCP_RESP_OKAY);
      axi_wr(A_TX, 32'h1234, `VCP_RESP_OKAY);
   endtask
   task automatic t_linear();
      wait_oe(1);
      frame_end(16'h1234, 5'h0D);
      axi_rd(A_GAIN, 32'hFF, 32'hFA, `VCP_RESP_OKAY);
      axi_rd(A_ST, 32'h21, 32'h21, `VCP_RESP_OKAY);
      @(posedge ref_clk);
      {law_n, tx_mute, rx_mute} <= 3'b111;
      rx_word <= 16'h005A;
      rx_bits <= 5'h08;
   endtask
   task automatic t_companded();
      wait_oe(1);
      frame_end(16'h00FF, 5'h08);
      axi_rd(A_GAIN, 32'hFF, 32'h0, `VCP_RESP_OKAY);
      axi_rd(A_ST, 32'hE1, 32'hC1, `VCP_RESP_OKAY);
      @(posedge ref_clk);
      {law_n, tx_mute, rx_mute} <= 3'b000;
      rx_word <= 16'hFFFF;
      rx_bits <= 5'h10;
      axi_wr(A_TX, 32'h1001, `VCP_RESP_OKAY);
   endtask
   task automatic t_pd_in_word();
      wait_oe(1);
      axi_wr(A_CTRL, 32'h1, `VCP_RESP_OKAY);
      frame_end(16'h1001, 5'h0D);
      chk(32'(pd), 32'h1);
      axi_rd(A_ST, 32'h0B, 32'h0B, `VCP_RESP_OKAY);
   endtask
   task automatic t_buffer();
      axi_rd(A_RX, 32'h1FFFF, 32'h16ABC, `VCP_RESP_OKAY);
      axi_rd(A_RX, 32'h1FFFF, 32'h12000, `VCP_RESP_OKAY);
      axi_rd(A_RX, 32'h10000, 32'h0, `VCP_RESP_OKAY);
      axi_wr(A_ST, 32'h2, `VCP_RESP_OKAY);
      axi_rd(A_ST, 32'h2, 32'h0, `VCP_RESP_OKAY);
   endtask
   task automatic t_clock_loss();
      axi_wr(A_CTRL, 32'h0, `VCP_RESP_OKAY);
      run <= 0;
      repeat (500) @(negedge ref_clk);
      chk(32'({pd, tx_oe}), 32'h2);
      axi_rd(A_ST, 32'h10, 32'h10, `VCP_RESP_OKAY);
   endtask
   task automatic t_mid_reset();
      run <= 1'b1;
      @(posedge ref_clk);
      rst_n <= 1'b0;
      // Held past the minimum pulse with the master clock running again
      repeat (120) @(posedge ref_clk);
      chk(32'({pd, tx_oe, bvalid, rvalid, awready, arready}), 32'h3);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      axi_rd(A_ST, 32'h18, 32'h0, `VCP_RESP_OKAY);
   endtask
   initial begin
      // A real falling edge, so the design is cleared before the first clock edge
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_linear();
      t_companded();
      t_pd_in_word();
      t_buffer();
      t_clock_loss();
      t_mid_reset();
      end_sim();
   end
endmodule
`default_nettype wire

// ### vcp_serial_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module vcp_serial_port_props (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_mclk,
   input wire logic o_serial_tx_out,
   input wire logic o_serial_tx_oe,
   input wire logic o_power_down,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // ==========================================================
   // Master clock idle counter, saturating so it never wraps back to zero
   logic [9:0] idle_r;
   logic mclk_r;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         idle_r <= 10'h000;
         mclk_r <= 1'b0;
      end else begin
         mclk_r <= i_mclk;
         idle_r <= (mclk_r != i_mclk) ? 10'h000 : (&idle_r ? idle_r : idle_r + 10'h001);
      end
   end
   // ==========================================================
   // Properties
   reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n |->
      !o_serial_tx_oe && !o_power_down && !o_s_axi_bvalid && !o_s_axi_rvalid)
      else $error("outputs active during reset");
   idle_low_a: assert property (!o_serial_tx_oe |-> !o_serial_tx_out)
      else $error("transmit data not low while released");
   clk_loss_a: assert property (idle_r > 10'h1A0 |-> !o_serial_tx_oe && o_power_down)
      else $error("no power-down after master clock loss");
   bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
      o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
      o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read data dropped early");
   wr_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
      else $error("write taken while response pending");
   wr_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
      o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid)
      else $error("write response late");
   rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=>
      o_s_axi_rvalid && !o_s_axi_arready)
      else $error("read response late");
endmodule
bind vcp_serial_port vcp_serial_port_props u_props (.i_ref_clk, .i_rst_n, .i_mclk,
   .o_serial_tx_out, .o_serial_tx_oe, .o_power_down, .i_s_axi_awvalid, .o_s_axi_awready,
   .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
   .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready);
`default_nettype wire

// ### vcp_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vcp_stream_if;
   logic valid;
   logic ready;
   vcp_pkg::vcp_word_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
